// [pcg_consts.svh]
// Purpose: Offsets, field positions and reset values of the peripheral clock gating bank
// Assumes: 32-bit register port, byte addresses
// Notes:   Definitions only
`ifndef PCG_CONSTS_SVH
`define PCG_CONSTS_SVH

// ==================================================
// Register offsets
`define PCG_OFF_RUN1      12'h104
`define PCG_OFF_SLEEP1    12'h114
`define PCG_OFF_DEEP1     12'h124
`define PCG_OFF_DEEP0     12'h120
`define PCG_OFF_CTRL      12'h200
`define PCG_OFF_FLT_STAT  12'h204
`define PCG_OFF_FLT_MASK  12'h208

// ==================================================
// Writable bit masks
`define PCG_BANK1_MASK    32'h070f0013
`define PCG_BANK0_MASK    32'h00010348
`define PCG_CTRL_MASK     32'h00000001
`define PCG_FLT_MASK      32'h00000003

// ==================================================
// Field positions
`define PCG_B1_ASER0      0
`define PCG_B1_ASER1      1
`define PCG_B1_SSER0      4
`define PCG_B1_TMR0       16
`define PCG_B1_CMP0       24
`define PCG_B0_WDOG       3
`define PCG_B0_HIBER      6
`define PCG_B0_SPD_LO     8
`define PCG_B0_CONV       16
`define PCG_CTRL_AUTO     0
`define PCG_FLT_RD        0
`define PCG_FLT_WR        1

// ==================================================
// Reset values
`define PCG_RST_GATE      32'h00000000
`define PCG_RST_CTRL      32'h00000000

`endif

// [pcg_pkg.sv]
// Purpose: Types of the peripheral clock gating bank
// Assumes: Nothing
// Notes:   Unit indices match the enable vector
package pcg_pkg;

   typedef enum logic [1:0] {
      PCG_MODE_RUN,
      PCG_MODE_SLEEP,
      PCG_MODE_DEEP
   } pcg_mode_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } pcg_reg_req_t;

   typedef struct packed {
      logic [3:0] unit;
      logic       rd;
      logic       wr;
   } pcg_periph_req_t;

   // Unit enable vector: 0..1 async serial 0..1, 2 sync serial 0, 3..6 counter 0..3,
   // 7..9 comparator 0..2, 10 watchdog, 11 hibernation, 12 converter
   localparam int PCG_UNITS = 13;

endpackage

// [pcg_fault_chk.sv]
// Purpose: Checks one peripheral access against the live enables
// Assumes: Request from logic on the same clock
// Notes:   Fault pulse one cycle after the access
`timescale 1ns/1ps
module pcg_fault_chk
   import pcg_pkg::*;
#(
   parameter int UNITS = PCG_UNITS
)(
   // Clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rstn,
   // Access and enables
   input  wire pcg_periph_req_t req,
   input  wire logic [UNITS-1:0] unit_en,
   // Result
   output logic                 fault_rd,
   output logic                 fault_wr
);

   typedef struct packed {
      logic rd;
      logic wr;
   } pcg_chk_state_t;

   pcg_chk_state_t st;
   pcg_chk_state_t next_st;
   logic           gated;

   always_comb begin
      gated = (int'(req.unit) >= UNITS) ? 1'b1 : ~unit_en[req.unit];
      next_st.rd = req.rd & gated;
      next_st.wr = req.wr & gated;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign fault_rd = st.rd;
   assign fault_wr = st.wr;

endmodule

// [pcg_gate_bank.sv]
// Purpose: Run, sleep and deep-sleep peripheral clock gating registers
// Assumes: Single ref_clk domain, mode request from the power controller
// Notes:   Enables are registered; clock gate cells sit outside
`timescale 1ns/1ps
`include "pcg_consts.svh"

module pcg_gate_bank
   import pcg_pkg::*;
#(
   parameter int UNITS = PCG_UNITS
)(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   // Register port
   input  wire pcg_reg_req_t     reg_req,
   output logic [31:0]           reg_rdata,
   // Power mode
   input  wire pcg_mode_t        mode,
   // Run- and sleep-mode bank0 enables from the clock configuration block
   input  wire logic [31:0]      run_gate_bank0,
   input  wire logic [31:0]      sleep_gate_bank0,
   // Peripheral access
   input  wire pcg_periph_req_t  periph_req,
   output logic                  bus_fault,
   // Gating result
   output logic [UNITS-1:0]      unit_clk_en,
   output logic [1:0]            converter_sample_speed,
   output logic                  automatic_gating_selector,
   output logic                  irq
);

   typedef struct packed {
      logic [31:0]      run_gate_bank1;
      logic [31:0]      sleep_gate_bank1;
      logic [31:0]      deep_sleep_gate_bank1;
      logic [31:0]      deep_sleep_gate_bank0;
      logic [31:0]      run_clock_configuration;
      logic [31:0]      flt_stat;
      logic [31:0]      flt_mask;
      logic [31:0]      rdata;
      logic [UNITS-1:0] en;
   } pcg_state_t;

   pcg_state_t   st;
   pcg_state_t   next_st;
   logic [31:0]  sel1;
   logic [31:0]  sel0;
   logic [31:0]  wmask;
   logic         fault_rd;
   logic         fault_wr;

   // ==================================================
   // Fault check against the enables in force
   pcg_fault_chk #(
      .UNITS (UNITS)
   ) u_chk (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .req      (periph_req),
      .unit_en  (st.en),
      .fault_rd (fault_rd),
      .fault_wr (fault_wr)
   );

   // ==================================================
   // Next state
   always_comb begin
      next_st = st;
      sel1    = st.run_gate_bank1;
      sel0    = run_gate_bank0;
      wmask   = 32'h00000000;

      // Register writes, reserved bits masked off
      if (reg_req.wr) begin
         case (reg_req.addr)
            `PCG_OFF_RUN1: begin
               next_st.run_gate_bank1 = reg_req.wdata & `PCG_BANK1_MASK;
            end
            `PCG_OFF_SLEEP1: begin
               next_st.sleep_gate_bank1 = reg_req.wdata & `PCG_BANK1_MASK;
            end
            `PCG_OFF_DEEP1: begin
               next_st.deep_sleep_gate_bank1 = reg_req.wdata & `PCG_BANK1_MASK;
            end
            `PCG_OFF_DEEP0: begin
               next_st.deep_sleep_gate_bank0 = reg_req.wdata & `PCG_BANK0_MASK;
            end
            `PCG_OFF_CTRL: begin
               next_st.run_clock_configuration = reg_req.wdata & `PCG_CTRL_MASK;
            end
            `PCG_OFF_FLT_STAT: begin
               wmask = reg_req.wdata & `PCG_FLT_MASK;
            end
            `PCG_OFF_FLT_MASK: begin
               next_st.flt_mask = reg_req.wdata & `PCG_FLT_MASK;
            end
            default: begin
            end
         endcase
      end

      // Sticky fault flags: set wins over write-one-to-clear
      next_st.flt_stat = st.flt_stat & ~wmask;
      if (fault_rd) begin
         next_st.flt_stat[`PCG_FLT_RD] = 1'b1;
      end
      if (fault_wr) begin
         next_st.flt_stat[`PCG_FLT_WR] = 1'b1;
      end

      // Register reads, unmapped reads zero
      next_st.rdata = 32'h00000000;
      if (reg_req.rd) begin
         case (reg_req.addr)
            `PCG_OFF_RUN1:     next_st.rdata = st.run_gate_bank1;
            `PCG_OFF_SLEEP1:   next_st.rdata = st.sleep_gate_bank1;
            `PCG_OFF_DEEP1:    next_st.rdata = st.deep_sleep_gate_bank1;
            `PCG_OFF_DEEP0:    next_st.rdata = st.deep_sleep_gate_bank0;
            `PCG_OFF_CTRL:     next_st.rdata = st.run_clock_configuration;
            `PCG_OFF_FLT_STAT: next_st.rdata = st.flt_stat;
            `PCG_OFF_FLT_MASK: next_st.rdata = st.flt_mask;
            default:           next_st.rdata = 32'h00000000;
         endcase
      end

      // Register set in force: per mode with automatic gating on, else the run set
      if (st.run_clock_configuration[`PCG_CTRL_AUTO]) begin
         case (mode)
            PCG_MODE_RUN: begin
               sel1 = st.run_gate_bank1;
               sel0 = run_gate_bank0;
            end
            PCG_MODE_SLEEP: begin
               sel1 = st.sleep_gate_bank1;
               sel0 = sleep_gate_bank0;
            end
            PCG_MODE_DEEP: begin
               sel1 = st.deep_sleep_gate_bank1;
               sel0 = st.deep_sleep_gate_bank0;
            end
            default: begin
               sel1 = st.run_gate_bank1;
               sel0 = run_gate_bank0;
            end
         endcase
      end

      // Per-unit enables
      next_st.en[0]    = sel1[`PCG_B1_ASER0];
      next_st.en[1]    = sel1[`PCG_B1_ASER1];
      next_st.en[2]    = sel1[`PCG_B1_SSER0];
      next_st.en[6:3]  = sel1[`PCG_B1_TMR0 +: 4];
      next_st.en[9:7]  = sel1[`PCG_B1_CMP0 +: 3];
      next_st.en[10]   = sel0[`PCG_B0_WDOG];
      next_st.en[11]   = sel0[`PCG_B0_HIBER];
      next_st.en[12]   = sel0[`PCG_B0_CONV];
   end

   // ==================================================
   // State register
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         st.run_gate_bank1          <= `PCG_RST_GATE;
         st.sleep_gate_bank1        <= `PCG_RST_GATE;
         st.deep_sleep_gate_bank1   <= `PCG_RST_GATE;
         st.deep_sleep_gate_bank0   <= `PCG_RST_GATE;
         st.run_clock_configuration <= `PCG_RST_CTRL;
         st.flt_stat                <= 32'h00000000;
         st.flt_mask                <= 32'h00000000;
         st.rdata                   <= 32'h00000000;
         st.en                      <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==================================================
   // Outputs
   assign reg_rdata                 = st.rdata;
   assign unit_clk_en               = st.en;
   assign bus_fault                 = fault_rd | fault_wr;
   assign converter_sample_speed    = st.deep_sleep_gate_bank0[`PCG_B0_SPD_LO +: 2];
   assign automatic_gating_selector = st.run_clock_configuration[`PCG_CTRL_AUTO];
   assign irq                       = |(st.flt_stat & st.flt_mask);

endmodule

// [pcg_gate_bank_properties.sv]
// Purpose: Port-level properties of the clock gating bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every pcg_gate_bank instance
`timescale 1ns/1ps
`include "pcg_consts.svh"
module pcg_gate_bank_properties
   import pcg_pkg::*;
#(
   parameter int UNITS = PCG_UNITS
)(
   // Clock and reset
   input wire logic             ref_clk,
   input wire logic             rstn,
   // Watched ports
   input wire pcg_reg_req_t     reg_req,
   input wire logic [31:0]      reg_rdata,
   input wire pcg_mode_t        mode,
   input wire logic [31:0]      run_gate_bank0,
   input wire logic [31:0]      sleep_gate_bank0,
   input wire pcg_periph_req_t  periph_req,
   input wire logic             bus_fault,
   input wire logic [UNITS-1:0] unit_clk_en,
   input wire logic [1:0]       converter_sample_speed,
   input wire logic             automatic_gating_selector,
   input wire logic             irq
);
   logic acc;
   logic gated;
   assign acc = periph_req.rd | periph_req.wr;
   assign gated = (periph_req.unit >= UNITS) || !unit_clk_en[periph_req.unit];
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ==================================================
   // Properties
   AST_FAULT: assert property (acc && gated |=> bus_fault)
      else $error("gated access gave no fault");
   AST_NOFAULT: assert property (!(acc && gated) |=> !bus_fault)
      else $error("fault without gated access");
   AST_RESET: assert property (disable iff (1'b0) !rstn |=> unit_clk_en == '0 && !irq && !bus_fault)
      else $error("outputs not cleared by reset");
   AST_RSVD: assert property (reg_req.rd && reg_req.addr inside {`PCG_OFF_RUN1, `PCG_OFF_SLEEP1, `PCG_OFF_DEEP1}
      |=> (reg_rdata & ~`PCG_BANK1_MASK) == '0) else $error("reserved bits read nonzero");
   AST_WRRUN: assert property ((reg_req.wr && reg_req.addr == `PCG_OFF_RUN1 && mode == PCG_MODE_RUN)
      ##1 mode == PCG_MODE_RUN |=> unit_clk_en[9:0] == {$past(reg_req.wdata[26:24], 2),
      $past(reg_req.wdata[19:16], 2), $past(reg_req.wdata[4], 2), $past(reg_req.wdata[1:0], 2)})
      else $error("run write not applied to enables");
   AST_RUNSEL: assert property ((mode == PCG_MODE_RUN || !automatic_gating_selector)
      |=> unit_clk_en[12:10] == {$past(run_gate_bank0[16]), $past(run_gate_bank0[6]), $past(run_gate_bank0[3])})
      else $error("run set not applied");
   AST_SLEEP: assert property ((automatic_gating_selector && mode == PCG_MODE_SLEEP)
      |=> unit_clk_en[12:10] == {$past(sleep_gate_bank0[16]), $past(sleep_gate_bank0[6]), $past(sleep_gate_bank0[3])})
      else $error("sleep set not applied");
   AST_IRQ: assert property ($rose(irq) |-> $past(bus_fault) || $past(reg_req.wr))
      else $error("interrupt rose without cause");
endmodule

bind pcg_gate_bank pcg_gate_bank_properties #(.UNITS(UNITS)) u_props (.ref_clk(ref_clk), .rstn(rstn),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .mode(mode), .run_gate_bank0(run_gate_bank0),
   .sleep_gate_bank0(sleep_gate_bank0), .periph_req(periph_req), .bus_fault(bus_fault),
   .unit_clk_en(unit_clk_en), .converter_sample_speed(converter_sample_speed),
   .automatic_gating_selector(automatic_gating_selector), .irq(irq));

// [tb_top.sv]
// Purpose: Self-checking bench of the clock gating bank
// Assumes: Register port strobes one cycle long
// Notes:   Enables checked one cycle after the preceding step; not every change is followed by a check
`timescale 1ns/1ps
`include "pcg_consts.svh"
module tb_top
   import pcg_pkg::*;
;
   logic            ref_clk, rstn, bus_fault, irq, sel;
   pcg_reg_req_t    req;
   pcg_periph_req_t preq;
   pcg_mode_t       mode;
   logic [31:0]     rb0, sb0, rdata;
   logic [12:0]     en;
   logic [1:0]      spd;
   int              num_errors, compares, cyc;
   logic [11:0]     offs [6] = '{`PCG_OFF_RUN1, `PCG_OFF_SLEEP1, `PCG_OFF_DEEP0, `PCG_OFF_DEEP1,
                                 `PCG_OFF_CTRL, `PCG_OFF_FLT_MASK};
   logic [31:0]     msk [6] = '{`PCG_BANK1_MASK, `PCG_BANK1_MASK, `PCG_BANK0_MASK, `PCG_BANK1_MASK,
                                `PCG_CTRL_MASK, `PCG_FLT_MASK};

   pcg_gate_bank #(.UNITS(PCG_UNITS)) uut (.ref_clk(ref_clk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
      .mode(mode), .run_gate_bank0(rb0), .sleep_gate_bank0(sb0), .periph_req(preq), .bus_fault(bus_fault),
      .unit_clk_en(en), .converter_sample_speed(spd), .automatic_gating_selector(sel), .irq(irq));

   // ==================================================
   // Clock and watchdog
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         num_errors++;
         close_out;
      end
   end

   // ==================================================
   // Tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk) req.wr <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge ref_clk) req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge ref_clk) req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task acc(input logic [3:0] u, input logic w, input logic exp);
      @(posedge ref_clk) preq <= '{u, !w, w};
      @(posedge ref_clk) preq <= '0;
      #1 chk({31'h0, bus_fault}, {31'h0, exp});
   endtask
   task en_chk(input logic [12:0] exp);
      @(posedge ref_clk) #1 chk({19'h0, en}, {19'h0, exp});
   endtask
   task close_out;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==================================================
   // Sequence
   initial begin
      ref_clk = 0;
      rstn = 0;
      req = '0;
      preq = '0;
      mode = PCG_MODE_RUN;
      rb0 = '0;
      sb0 = 32'h00000048;
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(offs[i], 32'h0);
      en_chk(13'h0);
      for (int i = 0; i < 6; i++) begin
         wr(offs[i], 32'hffffffff);
         rd(offs[i], msk[i]);
      end
      wr(12'h300, 32'hffffffff);
      rd(12'h300, 32'h0);
      chk({31'h0, sel}, 32'h1);
      en_chk(13'h03ff);
      @(posedge ref_clk) rb0 <= 32'h00010048;
      en_chk(13'h1fff);
      wr(`PCG_OFF_SLEEP1, 32'h00000003);
      @(posedge ref_clk) mode <= PCG_MODE_SLEEP;
      en_chk(13'h0c03);
      @(posedge ref_clk) mode <= PCG_MODE_DEEP;
      en_chk(13'h1fff);
      chk({30'h0, spd}, 32'h3);
      wr(`PCG_OFF_DEEP0, 32'h00000100);
      en_chk(13'h03ff);
      chk({30'h0, spd}, 32'h1);
      wr(`PCG_OFF_CTRL, 32'h0);
      en_chk(13'h1fff);
      chk({31'h0, sel}, 32'h0);
      @(posedge ref_clk) mode <= PCG_MODE_RUN;
      wr(`PCG_OFF_RUN1, 32'h00000001);
      @(posedge ref_clk) rb0 <= '0;
      acc(4'd0, 1'b0, 1'b0);
      acc(4'd1, 1'b0, 1'b1);
      acc(4'd10, 1'b1, 1'b1);
      acc(4'd15, 1'b1, 1'b1);
      rd(`PCG_OFF_FLT_STAT, 32'h3);
      chk({31'h0, irq}, 32'h1);
      wr(`PCG_OFF_FLT_MASK, 32'h0);
      @(posedge ref_clk) #1 chk({31'h0, irq}, 32'h0);
      wr(`PCG_OFF_FLT_STAT, 32'h1);
      rd(`PCG_OFF_FLT_STAT, 32'h2);
      wr(`PCG_OFF_FLT_MASK, 32'h2);
      @(posedge ref_clk) #1 chk({31'h0, irq}, 32'h1);
      wr(`PCG_OFF_FLT_STAT, 32'h2);
      @(posedge ref_clk) #1 chk({31'h0, irq}, 32'h0);
      // Fault set and clear in one cycle: set wins
      fork
         acc(4'd1, 1'b0, 1'b1);
         begin
            @(posedge ref_clk);
            wr(`PCG_OFF_FLT_STAT, 32'h1);
         end
      join
      rd(`PCG_OFF_FLT_STAT, 32'h1);
      @(posedge ref_clk) rstn <= 1'b0;
      @(posedge ref_clk) rstn <= 1'b1;
      rd(`PCG_OFF_RUN1, 32'h0);
      en_chk(13'h0);
      close_out;
   end
endmodule
